/* rtl/rcpo_top.sv */
// Reference control registers, pixel operators, converter and traffic generator
`timescale 1ns/1ps
// Contract
// - Read data returns selected register contents
// - Control port is address-decoded register bank
// - Sixteen-bit command bus, two bits per output
// - Lookup replaces each pixel by table entry
// - Threshold gives 255 at/above level, else 0
// - Threshold handles sixteen mono pixels per clock
// - Converter emits row n of image n
// - Last row flags buffer end, sequence restarts
// - Converter outputs first image metadata
// - Traffic writes 1024-byte counter bursts, wraps
// - Each burst read back; wraparounds counted
// - Wraparound raises event with count second
// - Host defines first argument and triggers event
// - All I/O states readable; outputs commandable
// - Event register write raises one event
// - Coefficient writes fill table, index advancing
// - Nonzero level sets threshold; zero keeps; reset 1
// - Bypass on with 01, off with 10
module rcpo_top (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [15:0] userOutCtrl,
   input wire logic [7:0] userOutState,
   input wire logic [9:0] stdIoGroupAState,
   input wire logic [9:0] stdIoGroupBState,
   input wire logic [39:0] extLineState,
   input wire logic pixInValid,
   input wire logic [127:0] pixInData,
   input wire logic pixInSof,
   input wire logic pixInEol,
   input wire logic pixInEof,
   input wire logic [15:0] imgHeight,
   input wire logic [31:0] metaIn,
   output logic pixOutValid,
   output logic [127:0] pixOutData,
   output logic pixOutEol,
   output logic bufferEndFlag,
   output logic [31:0] metaOut,
   output logic memWrValid,
   output logic memRdValid,
   output logic [31:0] memAddr,
   output logic [127:0] memWrData,
   input wire logic memReady,
   output logic logEvent,
   output logic [31:0] logEventArgFirst,
   output logic [31:0] logEventArgSecond
);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic bypassNext(input logic [1:0] code, input logic cur);
      bypassNext = (code == rcpo_pkg::CODE_ON) ? 1'b1 : (code == rcpo_pkg::CODE_OFF) ? 1'b0 : cur;
   endfunction : bypassNext

   function automatic logic [1:0] bypassCode(input logic byp);
      bypassCode = byp ? rcpo_pkg::CODE_ON : rcpo_pkg::CODE_OFF;
   endfunction : bypassCode

   // ---------------------------------------------------------------
   // Register bank over APB
   // ---------------------------------------------------------------
   logic [15:0] regIdx;
   logic apbWr, apbSetupRd;
   logic [31:0] rdMux;
   logic [31:0] scratch_q, scratch_d, argFirst_q, argFirst_d;
   logic tgEnable_q, tgEnable_d;
   logic [15:0] uoCtrl_q, uoCtrl_d;
   logic convByp_q, convByp_d, lutByp_q, lutByp_d, thrByp_q, thrByp_d;
   logic lutDone_q, lutDone_d;
   logic [7:0] lutIdx_q, lutIdx_d, thrLevel_q, thrLevel_d;
   logic [7:0] lutMem_q [256];
   logic [7:0] lutMem_d [256];
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, evWr;
   logic [31:0] wrapCnt_q;

   assign regIdx = paddr[17:2];
   assign apbWr = psel & penable & pready_q & pwrite;
   assign apbSetupRd = psel & ~penable & ~pwrite;
   assign evWr = apbWr & (regIdx == rcpo_pkg::IDX_EVENT);

   always_comb begin
      case (regIdx)
         rcpo_pkg::IDX_SCRATCH: rdMux = scratch_q;
         rcpo_pkg::IDX_TRAFFIC: rdMux = {31'h0, tgEnable_q};
         rcpo_pkg::IDX_UO_CTRL: rdMux = {16'h0, uoCtrl_q};
         rcpo_pkg::IDX_UO_STATE: rdMux = {24'h0, userOutState};
         rcpo_pkg::IDX_IO_A: rdMux = {22'h0, stdIoGroupAState};
         rcpo_pkg::IDX_IO_B: rdMux = {22'h0, stdIoGroupBState};
         rcpo_pkg::IDX_EXT_A: rdMux = extLineState[31:0];
         rcpo_pkg::IDX_EXT_B: rdMux = {24'h0, extLineState[39:32]};
         rcpo_pkg::IDX_WRAP_CNT: rdMux = wrapCnt_q;
         rcpo_pkg::IDX_CONV: rdMux = {30'h0, bypassCode(convByp_q)};
         rcpo_pkg::IDX_EVENT: rdMux = argFirst_q;
         rcpo_pkg::IDX_LUT: rdMux = {22'h0, bypassCode(lutByp_q), 3'h0, lutDone_q, 4'h0};
         rcpo_pkg::IDX_THRESH: rdMux = {22'h0, bypassCode(thrByp_q), thrLevel_q};
         default: rdMux = 32'h0;
      endcase
   end

   always_comb begin
      scratch_d = scratch_q;
      argFirst_d = argFirst_q;
      tgEnable_d = tgEnable_q;
      uoCtrl_d = uoCtrl_q;
      convByp_d = convByp_q;
      lutByp_d = lutByp_q;
      thrByp_d = thrByp_q;
      lutDone_d = lutDone_q;
      lutIdx_d = lutIdx_q;
      thrLevel_d = thrLevel_q;
      lutMem_d = lutMem_q;
      pready_d = psel & ~penable;
      prdata_d = apbSetupRd ? rdMux : prdata_q;
      if (apbWr) begin
         case (regIdx)
            rcpo_pkg::IDX_SCRATCH: scratch_d = pwdata;
            rcpo_pkg::IDX_TRAFFIC: tgEnable_d = pwdata[0];
            rcpo_pkg::IDX_UO_CTRL: uoCtrl_d = pwdata[15:0];
            rcpo_pkg::IDX_CONV: convByp_d = bypassNext(pwdata[1:0], convByp_q);
            rcpo_pkg::IDX_EVENT: argFirst_d = pwdata;
            rcpo_pkg::IDX_LUT: begin
               lutByp_d = bypassNext(pwdata[rcpo_pkg::BYP_LSB +: 2], lutByp_q);
               if (pwdata[rcpo_pkg::LUT_START_BIT]) begin
                  lutIdx_d = 8'h00;
                  lutDone_d = 1'b0;
               end
            end
            rcpo_pkg::IDX_LUT_COEF: begin
               lutMem_d[lutIdx_q] = pwdata[7:0];
               lutIdx_d = lutIdx_q + 8'h01;
               if (lutIdx_q == rcpo_pkg::PIX_HIGH) begin
                  lutDone_d = 1'b1;
               end
            end
            rcpo_pkg::IDX_THRESH: begin
               if (pwdata[7:0] != rcpo_pkg::PIX_LOW) begin
                  thrLevel_d = pwdata[7:0];
               end
               thrByp_d = bypassNext(pwdata[rcpo_pkg::BYP_LSB +: 2], thrByp_q);
            end
            default: scratch_d = scratch_q;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         scratch_q <= rcpo_pkg::SCRATCH_RST;
         argFirst_q <= 32'h0;
         tgEnable_q <= 1'b0;
         uoCtrl_q <= 16'h0;
         convByp_q <= 1'b1;
         lutByp_q <= 1'b1;
         thrByp_q <= 1'b1;
         lutDone_q <= 1'b0;
         lutIdx_q <= 8'h00;
         thrLevel_q <= rcpo_pkg::THRESH_RST;
         for (int i = 0; i < 256; i++) begin
            lutMem_q[i] <= 8'h00;
         end
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
      end else begin
         scratch_q <= scratch_d;
         argFirst_q <= argFirst_d;
         tgEnable_q <= tgEnable_d;
         uoCtrl_q <= uoCtrl_d;
         convByp_q <= convByp_d;
         lutByp_q <= lutByp_d;
         thrByp_q <= thrByp_d;
         lutDone_q <= lutDone_d;
         lutIdx_q <= lutIdx_d;
         thrLevel_q <= thrLevel_d;
         lutMem_q <= lutMem_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = 1'b0;
   assign userOutCtrl = uoCtrl_q;

   // ---------------------------------------------------------------
   // Pixel pipeline: lookup, threshold, image-to-row
   // ---------------------------------------------------------------
   logic [127:0] lutOut, thrOut, s1Data_q, s2Data_q, outData_q;
   logic [2:0] s1Flags_q, s2Flags_q;
   logic s1Valid_q, s2Valid_q, outValid_q, outEol_q, endFlag_q;
   logic [15:0] lineCnt_q, lineCnt_d, seqIdx_q, seqIdx_d;
   logic [31:0] meta_q, meta_d;
   logic seqLast, rowHit, outValid_d, outEol_d, endFlag_d;

   for (genvar k = 0; k < rcpo_pkg::PIX_N; k++) begin : g_pix
      assign lutOut[8*k +: 8] = lutByp_q ? pixInData[8*k +: 8] : lutMem_q[pixInData[8*k +: 8]];
      assign thrOut[8*k +: 8] = thrByp_q ? s1Data_q[8*k +: 8] :
         (s1Data_q[8*k +: 8] >= thrLevel_q) ? rcpo_pkg::PIX_HIGH : rcpo_pkg::PIX_LOW;
   end

   assign seqLast = (seqIdx_q == imgHeight - 16'h0001);
   assign rowHit = (lineCnt_q == seqIdx_q);

   always_comb begin
      lineCnt_d = lineCnt_q;
      seqIdx_d = seqIdx_q;
      meta_d = meta_q;
      outValid_d = 1'b0;
      outEol_d = 1'b0;
      endFlag_d = 1'b0;
      if (s2Valid_q) begin
         if (convByp_q) begin
            outValid_d = 1'b1;
            outEol_d = s2Flags_q[1];
            meta_d = s2Flags_q[0] ? metaIn : meta_q;
         end else begin
            outValid_d = rowHit;
            outEol_d = rowHit & s2Flags_q[1];
            endFlag_d = rowHit & s2Flags_q[1] & seqLast;
            if (s2Flags_q[0] && seqIdx_q == 16'h0000) begin
               meta_d = metaIn;
            end
            if (s2Flags_q[2]) begin
               lineCnt_d = 16'h0000;
               seqIdx_d = seqLast ? 16'h0000 : seqIdx_q + 16'h0001;
            end else if (s2Flags_q[1]) begin
               lineCnt_d = lineCnt_q + 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s1Valid_q <= 1'b0;
         s2Valid_q <= 1'b0;
         s1Data_q <= 128'h0;
         s2Data_q <= 128'h0;
         s1Flags_q <= 3'h0;
         s2Flags_q <= 3'h0;
         outValid_q <= 1'b0;
         outData_q <= 128'h0;
         outEol_q <= 1'b0;
         endFlag_q <= 1'b0;
         lineCnt_q <= 16'h0000;
         seqIdx_q <= 16'h0000;
         meta_q <= 32'h0;
      end else begin
         s1Valid_q <= pixInValid;
         s1Data_q <= lutOut;
         s1Flags_q <= {pixInEof, pixInEol, pixInSof};
         s2Valid_q <= s1Valid_q;
         s2Data_q <= thrOut;
         s2Flags_q <= s1Flags_q;
         outValid_q <= outValid_d;
         outData_q <= s2Data_q;
         outEol_q <= outEol_d;
         endFlag_q <= endFlag_d;
         lineCnt_q <= lineCnt_d;
         seqIdx_q <= seqIdx_d;
         meta_q <= meta_d;
      end
   end

   assign pixOutValid = outValid_q;
   assign pixOutData = outData_q;
   assign pixOutEol = outEol_q;
   assign bufferEndFlag = endFlag_q;
   assign metaOut = meta_q;

   // ---------------------------------------------------------------
   // Memory traffic generator and event sources
   // ---------------------------------------------------------------
   rcpo_pkg::rcpo_tg_e tgState_q, tgState_d;
   logic [31:0] addr_q, addr_d, wrapCnt_d, argSecond_q, argSecond_d;
   logic [5:0] beat_q, beat_d;
   logic [7:0] pattern_q, pattern_d;
   logic [127:0] wrData_d, wrData_q;
   logic wrapEv, event_q;

   for (genvar b = 0; b < rcpo_pkg::BEAT_BYTES; b++) begin : g_pat
      assign wrData_d[8*b +: 8] = pattern_d + 8'(b);
   end

   always_comb begin
      tgState_d = tgState_q;
      addr_d = addr_q;
      beat_d = beat_q;
      pattern_d = pattern_q;
      wrapCnt_d = wrapCnt_q;
      wrapEv = 1'b0;
      case (tgState_q)
         rcpo_pkg::TG_IDLE: begin
            if (tgEnable_q) begin
               tgState_d = rcpo_pkg::TG_WRITE;
            end
         end
         rcpo_pkg::TG_WRITE: begin
            if (memReady) begin
               pattern_d = pattern_q + rcpo_pkg::BEAT_STEP;
               beat_d = beat_q + 6'h01;
               if (beat_q == rcpo_pkg::LAST_BEAT) begin
                  tgState_d = rcpo_pkg::TG_READ;
               end
            end
         end
         rcpo_pkg::TG_READ: begin
            if (memReady) begin
               beat_d = beat_q + 6'h01;
               if (beat_q == rcpo_pkg::LAST_BEAT) begin
                  tgState_d = rcpo_pkg::TG_IDLE;
                  if (addr_q == rcpo_pkg::WRAP_ADDR - rcpo_pkg::BURST_BYTES) begin
                     addr_d = 32'h0;
                     wrapCnt_d = wrapCnt_q + 32'h1;
                     wrapEv = 1'b1;
                  end else begin
                     addr_d = addr_q + rcpo_pkg::BURST_BYTES;
                  end
               end
            end
         end
         default: tgState_d = rcpo_pkg::TG_IDLE;
      endcase
      argSecond_d = wrapEv ? wrapCnt_d : argSecond_q;
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         tgState_q <= rcpo_pkg::TG_IDLE;
         addr_q <= 32'h0;
         beat_q <= 6'h00;
         pattern_q <= 8'h00;
         wrapCnt_q <= 32'h0;
         wrData_q <= 128'h0;
         argSecond_q <= 32'h0;
         event_q <= 1'b0;
      end else begin
         tgState_q <= tgState_d;
         addr_q <= addr_d;
         beat_q <= beat_d;
         pattern_q <= pattern_d;
         wrapCnt_q <= wrapCnt_d;
         wrData_q <= wrData_d;
         argSecond_q <= argSecond_d;
         event_q <= evWr | wrapEv;
      end
   end

   assign memWrValid = (tgState_q == rcpo_pkg::TG_WRITE);
   assign memRdValid = (tgState_q == rcpo_pkg::TG_READ);
   assign memAddr = addr_q;
   assign memWrData = wrData_q;
   assign logEvent = event_q;
   assign logEventArgFirst = argFirst_q;
   assign logEventArgSecond = argSecond_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   sequence seqWrite(logic [15:0] idx);
      psel && penable && pready && pwrite && paddr[17:2] == idx;
   endsequence

   chk_event_write_arg: assert property (seqWrite(rcpo_pkg::IDX_EVENT) |=> logEvent && logEventArgFirst == $past(pwdata)) else $error("event write lost");
   chk_thresh_zero_hold: assert property (seqWrite(rcpo_pkg::IDX_THRESH) && pwdata[7:0] == 8'h00 |=> $stable(thrLevel_q)) else $error("zero level changed threshold");
   chk_uo_ctrl_drive: assert property (seqWrite(rcpo_pkg::IDX_UO_CTRL) |=> userOutCtrl == $past(pwdata[15:0])) else $error("command bus not updated");
   chk_unmapped_read_zero: assert property (psel && !penable && !pwrite && paddr[17:2] == 16'h0010 |=> pready && prdata == 32'h0) else $error("unmapped read not zero");
   chk_thresh_pixel_out: assert property (s1Valid_q && !thrByp_q |=> s2Data_q[7:0] == (($past(s1Data_q[7:0]) >= $past(thrLevel_q)) ? 8'hFF : 8'h00)) else $error("threshold output wrong");
   chk_lut_lookup: assert property (pixInValid && !lutByp_q |=> s1Data_q[15:8] == $past(lutMem_q[pixInData[15:8]])) else $error("lookup output wrong");
   chk_wrap_event_arg: assert property (wrapEv |=> logEvent && logEventArgSecond == wrapCnt_q && memAddr == 32'h0) else $error("wrap event wrong");
   chk_burst_readback: assert property (memWrValid && memReady && beat_q == 6'h3F |=> memRdValid && $stable(memAddr) ##0 memRdValid [*1]) else $error("no readback after burst");
   chk_addr_range: assert property (memAddr < 32'h4000_0000 && memAddr[9:0] == 10'h000) else $error("address out of range");
   chk_buffer_end_row: assert property (bufferEndFlag |-> pixOutEol && pixOutValid) else $error("end flag off row end");
endmodule : rcpo_top

/* pkg/rcpo_pkg.sv */
// Constants for the reference control and pixel operations block
package rcpo_pkg;
   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [15:0] IDX_SCRATCH = 16'h0000;
   localparam logic [15:0] IDX_TRAFFIC = 16'h0001;
   localparam logic [15:0] IDX_UO_CTRL = 16'h0002;
   localparam logic [15:0] IDX_UO_STATE = 16'h0003;
   localparam logic [15:0] IDX_IO_A = 16'h0004;
   localparam logic [15:0] IDX_IO_B = 16'h0005;
   localparam logic [15:0] IDX_EXT_A = 16'h0006;
   localparam logic [15:0] IDX_EXT_B = 16'h0007;
   localparam logic [15:0] IDX_WRAP_CNT = 16'h0008;
   localparam logic [15:0] IDX_CONV = 16'h1000;
   localparam logic [15:0] IDX_EVENT = 16'h1001;
   localparam logic [15:0] IDX_LUT = 16'h1002;
   localparam logic [15:0] IDX_LUT_COEF = 16'h1003;
   localparam logic [15:0] IDX_THRESH = 16'h1004;
   // ---------------------------------------------------------------
   // Field positions, codes and reset values
   // ---------------------------------------------------------------
   localparam int LUT_START_BIT = 0;
   localparam int LUT_DONE_BIT = 4;
   localparam int BYP_LSB = 8;
   localparam logic [1:0] CODE_ON = 2'h1;
   localparam logic [1:0] CODE_OFF = 2'h2;
   localparam logic [7:0] THRESH_RST = 8'h01;
   localparam logic [7:0] PIX_HIGH = 8'hFF;
   localparam logic [7:0] PIX_LOW = 8'h00;
   localparam logic [31:0] SCRATCH_RST = 32'h0000_0000;
   // ---------------------------------------------------------------
   // Stream and memory geometry
   // ---------------------------------------------------------------
   localparam int PIX_N = 16;
   localparam int BEAT_BYTES = 16;
   localparam logic [31:0] BURST_BYTES = 32'h0000_0400;
   localparam logic [5:0] LAST_BEAT = 6'h3F;
   localparam logic [31:0] WRAP_ADDR = 32'h4000_0000;
   localparam logic [7:0] BEAT_STEP = 8'h10;
   typedef enum logic [1:0] {
      TG_IDLE = 2'h0,
      TG_WRITE = 2'h1,
      TG_READ = 2'h3
   } rcpo_tg_e;
endpackage : rcpo_pkg

/* verif/rcpo_far_model.sv */
// Framework-side model: user output register and memory ready
`timescale 1ns/1ps
module rcpo_far_model (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [15:0] userOutCtrl,
   output logic [7:0] userOutState,
   output logic memReady
);
   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   logic [15:0] ctrlSeen_q, ctrlSeen_d;
   logic [7:0] state_q, state_d;
   logic [7:0] lfsr_q, lfsr_d;
   always_comb begin
      state_d = state_q;
      ctrlSeen_d = userOutCtrl;
      for (int k = 0; k < 8; k++) begin
         if (userOutCtrl[2*k+:2] != ctrlSeen_q[2*k+:2]) begin
            if (userOutCtrl[2*k+:2] == 2'h1) begin
               state_d[k] = 1'b1;
            end else if (userOutCtrl[2*k+:2] == 2'h2) begin
               state_d[k] = 1'b0;
            end
         end
      end
      lfsr_d = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
   end
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrlSeen_q <= 16'h0000;
         state_q <= 8'h00;
         lfsr_q <= 8'hA5;
      end else begin
         ctrlSeen_q <= ctrlSeen_d;
         state_q <= state_d;
         lfsr_q <= lfsr_d;
      end
   end
   assign userOutState = state_q;
   assign memReady = lfsr_q[0] | lfsr_q[3];
endmodule : rcpo_far_model

/* verif/tb.sv */
// Self-checking bench for the reference control and pixel block
`timescale 1ns/1ps
module tb;
   logic sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [17:0] paddr = 18'h0;
   logic [31:0] pwdata = 32'h0, metaIn = 32'h0, s;
   logic [9:0] ioA = 10'h0, ioB = 10'h0;
   logic [39:0] ext = 40'h0;
   logic pixInValid = 1'b0, pixInSof = 1'b0, pixInEol = 1'b0, pixInEof = 1'b0;
   logic [127:0] pixInData = 128'h0, d;
   logic [7:0] lv;
   wire logic [31:0] prdata, metaOut, memAddr, logEventArgFirst, logEventArgSecond;
   wire logic [127:0] pixOutData, memWrData;
   wire logic [15:0] userOutCtrl;
   wire logic [7:0] userOutState;
   wire logic pready, pslverr, pixOutValid, pixOutEol, bufferEndFlag;
   wire logic memWrValid, memRdValid, memReady, logEvent;
   logic [31:0] rdQ[$], evQ[$];
   logic [127:0] pxQ[$];
   int nErrors = 0, checkCount = 0, n, nEnd = 0;
   always #2.5 sys_clk = ~sys_clk;
   rcpo_top i_dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .userOutCtrl(userOutCtrl), .userOutState(userOutState),
      .stdIoGroupAState(ioA), .stdIoGroupBState(ioB), .extLineState(ext),
      .pixInValid(pixInValid), .pixInData(pixInData), .pixInSof(pixInSof),
      .pixInEol(pixInEol), .pixInEof(pixInEof), .imgHeight(16'h0004), .metaIn(metaIn),
      .pixOutValid(pixOutValid), .pixOutData(pixOutData), .pixOutEol(pixOutEol),
      .bufferEndFlag(bufferEndFlag), .metaOut(metaOut), .memWrValid(memWrValid),
      .memRdValid(memRdValid), .memAddr(memAddr), .memWrData(memWrData),
      .memReady(memReady), .logEvent(logEvent), .logEventArgFirst(logEventArgFirst),
      .logEventArgSecond(logEventArgSecond));
   rcpo_far_model i_far (.sys_clk(sys_clk), .resetn(resetn), .userOutCtrl(userOutCtrl),
      .userOutState(userOutState), .memReady(memReady));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
      checkCount++;
      if (got !== exp) begin
         nErrors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] v);
      int w;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'h0};
      pwdata <= v;
      @(posedge sys_clk);
      penable <= 1'b1;
      w = 0;
      do begin
         @(posedge sys_clk);
         w++;
      end while (pready !== 1'b1 && w < 50);
      if (w >= 50) check("pready", 1'b1, 1'b0);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb
   task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
      rdQ.push_back(exp);
      apb(1'b0, idx, 32'h0);
   endtask : rd
   function automatic logic [127:0] thr(input logic [127:0] v, input logic [7:0] l);
      for (int k = 0; k < 16; k++) thr[8*k+:8] = (v[8*k+:8] >= l) ? 8'hFF : 8'h00;
   endfunction : thr
   task automatic px(input logic [127:0] v, input logic [127:0] e, input logic [2:0] f,
      input logic keep);
      if (keep) pxQ.push_back(e);
      pixInValid <= 1'b1;
      pixInData <= v;
      pixInSof <= f[0];
      pixInEol <= f[1];
      pixInEof <= f[2];
      metaIn <= $urandom;
      @(posedge sys_clk);
      pixInValid <= 1'b0;
      pixInSof <= 1'b0;
      pixInEol <= 1'b0;
      pixInEof <= 1'b0;
      repeat (5) @(posedge sys_clk);
   endtask : px
   task printVerdict;
      $display("errors %0d checks %0d", nErrors, checkCount);
      if (nErrors == 0 && checkCount > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : printVerdict
   // ---------------------------------------------------------------
   // Output watcher
   // ---------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (rdQ.size() > 0) check("prdata", rdQ.pop_front(), prdata);
         else check("unexpected read", 1'b0, 1'b1);
      end
      if (pixOutValid === 1'b1) begin
         if (pxQ.size() > 0) check("pixOutData", pxQ.pop_front(), pixOutData);
         else check("unexpected beat", 1'b0, 1'b1);
      end
      if (bufferEndFlag === 1'b1) nEnd++;
      if (logEvent === 1'b1) begin
         if (evQ.size() > 0) check("logEventArgFirst", evQ.pop_front(), logEventArgFirst);
         else check("unexpected event", 1'b0, 1'b1);
      end
   end
   // ---------------------------------------------------------------
   // Sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      #250000;
      nErrors++;
      printVerdict();
   end
   initial begin
      s = $urandom(32'h7619df94);
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      rd(rcpo_pkg::IDX_SCRATCH, rcpo_pkg::SCRATCH_RST);
      rd(rcpo_pkg::IDX_CONV, 32'h1);
      rd(rcpo_pkg::IDX_LUT, 32'h100);
      rd(rcpo_pkg::IDX_THRESH, 32'h101);
      apb(1'b1, 16'h0010, 32'hDEADBEEF);
      rd(16'h0010, 32'h0);
      rd(rcpo_pkg::IDX_SCRATCH, rcpo_pkg::SCRATCH_RST);
      s = $urandom;
      apb(1'b1, rcpo_pkg::IDX_SCRATCH, s);
      rd(rcpo_pkg::IDX_SCRATCH, s);
      ioA <= 10'($urandom);
      ioB <= 10'($urandom);
      ext <= {8'($urandom), 32'($urandom)};
      @(posedge sys_clk);
      rd(rcpo_pkg::IDX_IO_A, {22'h0, ioA});
      rd(rcpo_pkg::IDX_IO_B, {22'h0, ioB});
      rd(rcpo_pkg::IDX_EXT_A, ext[31:0]);
      rd(rcpo_pkg::IDX_EXT_B, {24'h0, ext[39:32]});
      apb(1'b1, rcpo_pkg::IDX_UO_CTRL, 32'h5555);
      check("userOutCtrl", 16'h5555, userOutCtrl);
      rd(rcpo_pkg::IDX_UO_STATE, 32'hFF);
      apb(1'b1, rcpo_pkg::IDX_UO_CTRL, 32'h9999);
      rd(rcpo_pkg::IDX_UO_CTRL, 32'h9999);
      rd(rcpo_pkg::IDX_UO_STATE, 32'h55);
      for (int i = 0; i < 2; i++) begin
         s = $urandom;
         evQ.push_back(s);
         apb(1'b1, rcpo_pkg::IDX_EVENT, s);
      end
      lv = 8'($urandom_range(8'hFE, 8'h02));
      apb(1'b1, rcpo_pkg::IDX_THRESH, {22'h0, 2'h2, lv});
      apb(1'b1, rcpo_pkg::IDX_THRESH, 32'h200);
      rd(rcpo_pkg::IDX_THRESH, {22'h0, 2'h2, lv});
      for (int i = 0; i < 3; i++) begin
         d = {$urandom, $urandom, $urandom, $urandom};
         d[15:0] = {lv - 8'h01, lv};
         px(d, thr(d, lv), 3'h7, 1'b1);
      end
      apb(1'b1, rcpo_pkg::IDX_LUT, 32'h201);
      for (int i = 0; i < 256; i++) apb(1'b1, rcpo_pkg::IDX_LUT_COEF, {24'h0, ~8'(i)});
      rd(rcpo_pkg::IDX_LUT, 32'h210);
      apb(1'b1, rcpo_pkg::IDX_THRESH, 32'h100);
      d = {$urandom, $urandom, $urandom, $urandom};
      px(d, ~d, 3'h7, 1'b1);
      apb(1'b1, rcpo_pkg::IDX_CONV, 32'h2);
      for (int img = 0; img < 4; img++) begin
         for (int row = 0; row < 4; row++) begin
            d = {$urandom, $urandom, $urandom, $urandom};
            px(d, ~d, {row == 3, 1'b1, row == 0}, row == img);
         end
      end
      check("bufferEndFlag count", 1, nEnd);
      apb(1'b1, rcpo_pkg::IDX_TRAFFIC, 32'h1);
      n = 0;
      while (!(memWrValid === 1'b1 && memReady === 1'b1) && n < 200) begin
         @(posedge sys_clk);
         n++;
      end
      check("memWrData", 128'h0F0E0D0C0B0A09080706050403020100, memWrData);
      check("memAddr", 32'h0, memAddr);
      n = 0;
      while (memAddr !== rcpo_pkg::BURST_BYTES && n < 2000) begin
         @(posedge sys_clk);
         n++;
      end
      check("memAddr", rcpo_pkg::BURST_BYTES, memAddr);
      apb(1'b1, rcpo_pkg::IDX_TRAFFIC, 32'h0);
      rd(rcpo_pkg::IDX_WRAP_CNT, 32'h0);
      repeat (10) @(posedge sys_clk);
      check("queues", 32'h0, rdQ.size() + pxQ.size() + evQ.size());
      printVerdict();
   end
endmodule : tb
